// *** bench/ccd_pm_model.sv ***
// Purpose: program memory beside the decoder, plus a table data source
// Assumes: combinational read, word at pm_addr stands in the same cycle
// Notes: words past the array read as nop; bench fills mem directly
`timescale 1ns/1ns
module ccd_pm_model
  import ccd_pkg::*;
(
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic [21:0] tbl_addr,
  output logic [15:0] pm_data,
  output logic [7:0] tbl_rdata
);
  logic [15:0] mem [0:63];
  // out-of-range fetches must still decode, so they return nop
  assign pm_data = (pm_addr < 64) ? mem[pm_addr[5:0]] : 16'h0000;
  // table data follows the pointer so a wrong pointer shows up
  assign tbl_rdata = tbl_addr[7:0] ^ 8'h5a;
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for the control, literal and table decoder
// Assumes: program loaded while reset is held
// Notes: results read back over the register port and from the core's outputs
`timescale 1ns/1ns
module tb;
  import ccd_pkg::*;
  logic sys_clk = 0, rst_n = 0, wake_req = 0;
  logic [7:0] port_pins = 8'h0f, rdata, port_b_register, tbl_wdata;
  ccd_bus_s bus = '0;
  logic [15:0] pm_data;
  logic [7:0] tbl_rdata;
  logic [PC_W-1:0] pm_addr;
  logic [21:0] tbl_addr, wr_addr;
  logic tbl_rd, tbl_wr, nvm_busy, wdt_clear, standby, gie, pie;
  int err_total = 0, n_compared = 0, n_wdt, n_rd, n_wr, n_busy;
  always #25 sys_clk = ~sys_clk;
  ccd_pm_model i_pm (.pm_addr(pm_addr), .tbl_addr(tbl_addr), .pm_data(pm_data), .tbl_rdata(tbl_rdata));
  ccd_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pm_data(pm_data), .tbl_rdata(tbl_rdata),
    .wake_req(wake_req), .port_pins(port_pins), .bus(bus), .pm_addr(pm_addr), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .nvm_busy(nvm_busy), .wdt_clear(wdt_clear),
    .standby(standby), .global_high_irq_enable(gie), .peripheral_low_irq_enable(pie),
    .port_b_register(port_b_register), .rdata(rdata));
  // pulse counters, cleared by reset so each program starts fresh
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      n_wdt = 0; n_rd = 0; n_wr = 0; n_busy = 0;
    end else begin
      n_wdt += (wdt_clear === 1'b1);
      n_rd += (tbl_rd === 1'b1);
      n_busy += (nvm_busy === 1'b1);
      if (tbl_wr === 1'b1) begin
        n_wr++;
        wr_addr = tbl_addr;
      end
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hold reset, load the program, release, let it run
  task run(input logic [15:0] w [$], input int cyc);
    rst_n <= 0;
    for (int i = 0; i < 64; i++) i_pm.mem[i] = (i < w.size()) ? w[i] : 16'h0000;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    repeat (cyc) @(posedge sys_clk);
  endtask
  task bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask
  task t_literal;
    run('{16'h0e10, 16'h0f15, 16'h0825, 16'h0aff, 16'h0d02, 16'h0107, 16'h0b0f, 16'hf123,
      16'hef00, 16'hf008}, 30);
    rd_chk(RA_WORKING, 8'h0f);
    rd_chk(RA_FLAGS, 8'h18);
    rd_chk(RA_PROD_LO, 8'hfe);
    rd_chk(RA_PROD_HI, 8'h01);
    rd_chk(RA_BANK, 8'h07);
    chk(pm_addr >= 8 && pm_addr <= 9, 1);
    $display("test literal done");
  endtask
  task t_branch;
    // taken branch skips 3 and 4; call, push, pop, literal return, relative call, irq return
    run('{16'h0e80, 16'h0900, 16'he602, 16'h0107, 16'h0e22, 16'hec00, 16'hf00c, 16'hd802,
      16'hef00, 16'hf008, 16'h0010, 16'h0000, 16'h0005, 16'h0006, 16'h0c42}, 30);
    rd_chk(RA_BANK, 8'h00);
    rd_chk(RA_WORKING, 8'h42);
    chk(pm_addr >= 8 && pm_addr <= 9, 1);
    chk(gie, 1);
    chk(pie, 1);
    $display("test branch done");
  endtask
  task t_table;
    logic [7:0] d;
    // post-decrement from 0 lands the next write on a block end
    run('{16'h0004, 16'h0008, 16'h000e, 16'h000c, 16'h0003, 16'hef00, 16'hf005}, 20);
    chk(standby, 1);
    chk(n_wdt, 1);
    chk(n_rd, 1);
    chk(n_wr, 2);
    chk(n_busy, 3);
    chk(wr_addr, 22'h3fffff);
    rd_chk(RA_TABLE_LATCH, 8'h5a);
    chk(tbl_wdata, 8'h5a);
    @(posedge sys_clk) wake_req <= 1;
    @(posedge sys_clk) wake_req <= 0;
    repeat (4) @(posedge sys_clk);
    chk(standby, 0);
    bus_rd(RA_CORE_STAT, d);
    chk(d[1:0], 2'b01);
    $display("test table done");
  endtask
  task t_port;
    bus_wr(RA_PORT_LATCH, 8'hff);
    bus_wr(RA_PORT_TOGGLE, 8'h00);
    rd_chk(RA_PORT_LATCH, 8'h0f);
    chk(port_b_register, 8'h0f);
    rd_chk(4'hc, 8'h00);
    bus_wr(RA_WORKING, 8'h33);
    rd_chk(RA_WORKING, 8'h33);
    // prescaler restarts at the timer write, so the count holds for eight cycles
    bus_wr(RA_CTRL, 8'h03);
    bus_wr(RA_TIMER, 8'h40);
    repeat (5) @(posedge sys_clk);
    rd_chk(RA_TIMER, 8'h40);
    $display("test port done");
  endtask
  task print_verdict;
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
  initial begin
    t_literal();
    t_branch();
    t_table();
    t_port();
    print_verdict();
  end
endmodule

// *** design/ccd_core.sv ***
// Purpose: decode and run control, literal and table instructions of an 8-bit core
// Assumes: program word for pm_addr stands in the same cycle; table data likewise
// Notes: one instruction cycle per sys_clk; second cycles after taken branches, relative jumps and returns run as nops
// How it works
// - conditional branches 1110 0ccc: one cycle, two when taken
// - call is two words, 1110 110s then 1111, two cycles, s saves shadow
// - jump is two words 1110 1111 then 1111, two cycles, flags untouched
// - sleep 0003 and watchdog clear 0004 take one cycle, update timeout and power-down
// - 0006 drops the top return-stack entry, one cycle, no flags
// - 0005 pushes onto the return stack, one cycle, no flags
// - interrupt return 0010/0011: two cycles, enables both irq bits, s restores shadow
// - return with literal loads working register and returns in two cycles
// - literal add and subtract write working register and all five flags
// - literal and, or, xor write working register and only zero, negative
// - literal multiply and literal load take one cycle, no flags
// - 010k loads four bits into bank select, one cycle, no flags
// - pointer literal load: two words, twelve bits into pointer 0, 1 or 2; select 3 writes nothing
// - table reads 0008..000b, two cycles, four pointer update modes
// - table writes 000c..000f, same modes, two cycles or five when long
// - an internal write once started always runs to its end
// - port modify of itself uses the pin levels, not the latch
// - writing the timer clears its prescaler when assigned to it
// - a changed program counter costs a second cycle run as a nop
// - a lone 1111 word is a one-cycle nop; only its first word consumes it
`timescale 1ns/1ns
module ccd_core
  import ccd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] pm_data,
  input wire logic [7:0] tbl_rdata,
  input wire logic wake_req,
  input wire logic [7:0] port_pins,
  input wire ccd_bus_s bus,
  output logic [PC_W-1:0] pm_addr,
  output logic [21:0] tbl_addr,
  output logic [7:0] tbl_wdata,
  output logic tbl_rd,
  output logic tbl_wr,
  output logic nvm_busy,
  output logic wdt_clear,
  output logic standby,
  output logic global_high_irq_enable,
  output logic peripheral_low_irq_enable,
  output logic [7:0] port_b_register,
  output logic [7:0] rdata
);
  typedef struct packed {
    ccd_phase_e phase;
    logic [PC_W-1:0] pc;
    logic [15:0] word1;
    logic [7:0] working_register;
    ccd_flags_s flags;
    logic [3:0] bank_select_register;
    logic [3:0][11:0] indirect_pointer;
    logic [STK_DEPTH-1:0][PC_W-1:0] stack;
    logic [3:0] sp;
    logic [7:0] sh_working;
    ccd_flags_s sh_flags;
    logic [3:0] sh_bank;
    logic [15:0] prod;
    logic [21:0] tblptr;
    logic [7:0] tablat;
    logic tbl_is_wr;
    logic [1:0] tbl_mode;
    logic [1:0] nvm_cnt;
    logic timeout_status_bit;
    logic power_down_status_bit;
    logic gie_hi;
    logic gie_lo;
    logic [1:0] ctrl;
    logic [7:0] timer_zero_count;
    logic [2:0] prescale;
    logic [7:0] latch;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_q;
    logic rd_stb;
    logic wr_stb;
    logic wdt_pulse;
    logic [7:0] rdata;
  } ccd_state_s;

  ccd_state_s st;
  ccd_state_s next_st;
  logic [15:0] ins;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] br_short;
  logic [PC_W-1:0] br_long;
  logic [PC_W-1:0] stk_top;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] lit;
  logic cond;
  logic [21:0] ptr_pre;

  assign ins = pm_data;
  assign lit = ins[7:0];
  assign pc_inc = st.pc + PC_W'(1);
  assign br_short = pc_inc + PC_W'(signed'(ins[7:0]));
  assign br_long = pc_inc + PC_W'(signed'(ins[10:0]));
  assign stk_top = (st.sp == 4'h0) ? '0 : st.stack[3'(st.sp - 4'h1)];
  assign ptr_pre = (st.tbl_mode == 2'h3) ? st.tblptr + 22'h1 : st.tblptr;

  // condition select for the short conditional branches
  always_comb begin
    unique case (ins[10:8])
      3'h0: cond = st.flags.z;
      3'h1: cond = !st.flags.z;
      3'h2: cond = st.flags.c;
      3'h3: cond = !st.flags.c;
      3'h4: cond = st.flags.ov;
      3'h5: cond = !st.flags.ov;
      3'h6: cond = st.flags.n;
      3'h7: cond = !st.flags.n;
    endcase
  end

  // whole next state; decode only acts in the execute phase
  always_comb begin
    next_st = st;
    sum = 9'h0;
    nib = 5'h0;
    next_st.wdt_pulse = 1'b0;
    next_st.rd_stb = 1'b0;
    next_st.wr_stb = 1'b0;
    // pins pass three flops; a level counts once the last two agree
    next_st.pin_s1 = port_pins;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    if (st.pin_s2 == st.pin_s3) begin
      next_st.pin_q = st.pin_s3;
    end
    // timer runs each cycle or through its prescaler
    if (st.ctrl[CTRL_PSA]) begin
      next_st.prescale = st.prescale + 3'h1;
      if (st.prescale == PRESCALE_MAX) begin
        next_st.timer_zero_count = st.timer_zero_count + 8'h1;
      end
    end else begin
      next_st.timer_zero_count = st.timer_zero_count + 8'h1;
    end
    // internal write counts down on its own, nothing can cut it short
    if (st.nvm_cnt != 2'h0) begin
      next_st.nvm_cnt = st.nvm_cnt - 2'h1;
    end
    unique case (st.phase)
      CCD_EXEC: begin
        if (st.ctrl[CTRL_RUN]) begin
          next_st.pc = pc_inc;
          unique case (ins[15:12])
            HI_LONG: begin
              if (!ins[11]) begin
                if (cond) begin
                  next_st.pc = br_short;
                  next_st.phase = CCD_FLUSH;
                end
              end else if (ins[11:9] == SUB_CALL || ins[11:8] == SUB_PTRLOAD || ins[11:8] == SUB_JUMP) begin
                next_st.word1 = ins;
                next_st.phase = CCD_WORD2;
              end
            end
            HI_RELATIVE: begin
              if (ins[11] && st.sp < 4'(STK_DEPTH)) begin
                next_st.stack[3'(st.sp)] = pc_inc;
                next_st.sp = st.sp + 4'h1;
              end
              next_st.pc = br_long;
              next_st.phase = CCD_FLUSH;
            end
            HI_LITCTL: begin
              unique case (ins[11:8])
                4'h0: begin
                  if (ins == CW_SLEEP) begin
                    next_st.timeout_status_bit = 1'b1;
                    next_st.power_down_status_bit = 1'b0;
                    next_st.phase = CCD_STANDBY;
                  end else if (ins == CW_WDT) begin
                    next_st.timeout_status_bit = 1'b1;
                    next_st.power_down_status_bit = 1'b1;
                    next_st.wdt_pulse = 1'b1;
                  end else if (ins == CW_PUSH) begin
                    if (st.sp < 4'(STK_DEPTH)) begin
                      next_st.stack[3'(st.sp)] = pc_inc;
                      next_st.sp = st.sp + 4'h1;
                    end
                  end else if (ins == CW_POP) begin
                    if (st.sp != 4'h0) begin
                      next_st.sp = st.sp - 4'h1;
                    end
                  end else if (ins[15:1] == CW_INTERRUPT_RETURN_OP || ins[15:1] == CW_RETURN) begin
                    next_st.pc = stk_top;
                    if (st.sp != 4'h0) begin
                      next_st.sp = st.sp - 4'h1;
                    end
                    if (ins[15:1] == CW_INTERRUPT_RETURN_OP) begin
                      next_st.gie_hi = 1'b1;
                      next_st.gie_lo = 1'b1;
                    end
                    if (ins[0]) begin
                      next_st.working_register = st.sh_working;
                      next_st.flags = st.sh_flags;
                      next_st.bank_select_register = st.sh_bank;
                    end
                    next_st.phase = CCD_FLUSH;
                  end else if (ins[15:2] == CW_TABLE_READ_OP || ins[15:2] == CW_TABLE_WRITE_OP) begin
                    next_st.tbl_is_wr = ins[2];
                    next_st.tbl_mode = ins[1:0];
                    next_st.rd_stb = !ins[2];
                    next_st.wr_stb = ins[2];
                    next_st.phase = CCD_TABLE;
                  end
                end
                LIT_BANK: begin
                  if (ins[7:4] == 4'h0) begin
                    next_st.bank_select_register = ins[3:0];
                  end
                end
                LIT_ADD, LIT_SUB: begin
                  if (ins[11:8] == LIT_ADD) begin
                    sum = {1'b0, st.working_register} + {1'b0, lit};
                    nib = {1'b0, st.working_register[3:0]} + {1'b0, lit[3:0]};
                    next_st.flags.ov = (st.working_register[7] == lit[7]) && (sum[7] != lit[7]);
                  end else begin
                    // carry and digit carry read as no-borrow
                    sum = {1'b0, lit} + {1'b0, ~st.working_register} + 9'h1;
                    nib = {1'b0, lit[3:0]} + {1'b0, ~st.working_register[3:0]} + 5'h1;
                    next_st.flags.ov = (lit[7] != st.working_register[7]) && (sum[7] != lit[7]);
                  end
                  next_st.working_register = sum[7:0];
                  next_st.flags.c = sum[8];
                  next_st.flags.dc = nib[4];
                  next_st.flags.z = (sum[7:0] == 8'h0);
                  next_st.flags.n = sum[7];
                end
                LIT_AND, LIT_OR, LIT_XOR: begin
                  if (ins[11:8] == LIT_AND) begin
                    sum[7:0] = st.working_register & lit;
                  end else if (ins[11:8] == LIT_OR) begin
                    sum[7:0] = st.working_register | lit;
                  end else begin
                    sum[7:0] = st.working_register ^ lit;
                  end
                  next_st.working_register = sum[7:0];
                  next_st.flags.z = (sum[7:0] == 8'h0);
                  next_st.flags.n = sum[7];
                end
                LIT_RET: begin
                  next_st.working_register = lit;
                  next_st.pc = stk_top;
                  if (st.sp != 4'h0) begin
                    next_st.sp = st.sp - 4'h1;
                  end
                  next_st.phase = CCD_FLUSH;
                end
                LIT_MUL: next_st.prod = 16'(st.working_register) * 16'(lit);
                LIT_LOAD: next_st.working_register = lit;
                default: next_st.pc = pc_inc;
              endcase
            end
            default: next_st.pc = pc_inc;
          endcase
        end else begin
          next_st.pc = st.pc;
        end
      end
      CCD_WORD2: begin
        // the second word is data here and nowhere else
        next_st.phase = CCD_EXEC;
        next_st.pc = pc_inc;
        if (st.word1[11:8] == SUB_PTRLOAD) begin
          if (st.word1[5:4] != 2'h3) begin
            next_st.indirect_pointer[st.word1[5:4]] = {st.word1[3:0], ins[7:0]};
          end
        end else begin
          next_st.pc = PC_W'({st.word1[7:0], ins[11:0]});
          if (st.word1[11:9] == SUB_CALL) begin
            if (st.sp < 4'(STK_DEPTH)) begin
              next_st.stack[3'(st.sp)] = pc_inc;
              next_st.sp = st.sp + 4'h1;
            end
            if (st.word1[8]) begin
              next_st.sh_working = st.working_register;
              next_st.sh_flags = st.flags;
              next_st.sh_bank = st.bank_select_register;
            end
          end
        end
      end
      CCD_FLUSH: next_st.phase = CCD_EXEC;
      CCD_TABLE: begin
        next_st.phase = CCD_EXEC;
        if (!st.tbl_is_wr) begin
          next_st.tablat = tbl_rdata;
        end else if (ptr_pre[2:0] == NVM_BLOCK_LAST) begin
          next_st.nvm_cnt = NVM_WAIT_CNT;
          next_st.phase = CCD_NVM_WAIT;
        end
        unique case (st.tbl_mode)
          2'h0: next_st.tblptr = st.tblptr;
          2'h1: next_st.tblptr = st.tblptr + 22'h1;
          2'h2: next_st.tblptr = st.tblptr - 22'h1;
          2'h3: next_st.tblptr = ptr_pre;
        endcase
      end
      CCD_NVM_WAIT: begin
        if (st.nvm_cnt == 2'h1) begin
          next_st.phase = CCD_EXEC;
        end
      end
      CCD_STANDBY: begin
        if (wake_req) begin
          next_st.phase = CCD_EXEC;
        end
      end
      default: next_st.phase = CCD_EXEC;
    endcase
    // register port; writes here land after the instruction's own update
    next_st.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        RA_WORKING: next_st.rdata = st.working_register;
        RA_FLAGS: next_st.rdata = {3'h0, st.flags};
        RA_BANK: next_st.rdata = {4'h0, st.bank_select_register};
        RA_CTRL: next_st.rdata = {6'h0, st.ctrl};
        RA_TIMER: next_st.rdata = st.timer_zero_count;
        RA_PORT_LATCH: next_st.rdata = st.latch;
        RA_PORT_PINS: next_st.rdata = st.pin_q;
        RA_TABLE_LATCH: next_st.rdata = st.tablat;
        RA_PROD_LO: next_st.rdata = st.prod[7:0];
        RA_PROD_HI: next_st.rdata = st.prod[15:8];
        RA_CORE_STAT: next_st.rdata = {2'h0, st.nvm_cnt != 2'h0, st.phase == CCD_STANDBY,
                                       st.gie_lo, st.gie_hi, st.power_down_status_bit, st.timeout_status_bit};
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (bus.wr) begin
      unique case (bus.addr)
        RA_WORKING: next_st.working_register = bus.wdata;
        RA_CTRL: next_st.ctrl = bus.wdata[1:0];
        RA_TIMER: begin
          next_st.timer_zero_count = bus.wdata;
          if (st.ctrl[CTRL_PSA]) begin
            next_st.prescale = 3'h0;
          end
        end
        RA_PORT_LATCH: next_st.latch = bus.wdata;
        RA_PORT_TOGGLE: next_st.latch = st.pin_q ^ bus.wdata;
        RA_TABLE_LATCH: next_st.tablat = bus.wdata;
        default: next_st.latch = next_st.latch;
      endcase
    end
  end

  // single state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.working_register <= WORKING_RESET;
      st.timeout_status_bit <= 1'b1;
      st.power_down_status_bit <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs from the state flops only; tbl_addr adds the pre-increment
  assign pm_addr = st.pc;
  assign tbl_addr = ptr_pre;
  assign tbl_wdata = st.tablat;
  assign tbl_rd = st.rd_stb;
  assign tbl_wr = st.wr_stb;
  assign nvm_busy = st.nvm_cnt != 2'h0;
  assign wdt_clear = st.wdt_pulse;
  assign standby = st.phase == CCD_STANDBY;
  assign global_high_irq_enable = st.gie_hi;
  assign peripheral_low_irq_enable = st.gie_lo;
  assign port_b_register = st.latch;
  assign rdata = st.rdata;

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic run_exec;
  assign run_exec = st.phase == CCD_EXEC && st.ctrl[CTRL_RUN];

  a_branch_taken_flush: assert property (run_exec && ins[15:11] == 5'h1c && cond |=>
    st.phase == CCD_FLUSH ##1 st.phase == CCD_EXEC) else $error("taken branch not two cycles");
  a_call_second_word: assert property (run_exec && ins[15:9] == 7'h76 |=> st.phase == CCD_WORD2
    ##1 st.sp == $past(st.sp) + 4'h1 || $past(st.sp) == 4'(STK_DEPTH)) else $error("call push wrong");
  a_jump_keeps_flags: assert property (run_exec && ins[15:8] == 8'hef |=> ##1 $stable(st.flags))
    else $error("jump changed flags");
  a_sleep_status: assert property (run_exec && ins == CW_SLEEP |=> st.timeout_status_bit
    && !st.power_down_status_bit && standby) else $error("sleep status wrong");
  a_pop_drops_top: assert property (run_exec && ins == CW_POP && st.sp != 4'h0 |=>
    st.sp == $past(st.sp) - 4'h1 && $stable(st.flags)) else $error("pop wrong");
  a_interrupt_return_op_enables: assert property (run_exec && ins[15:1] == CW_INTERRUPT_RETURN_OP |=>
    st.gie_hi && st.gie_lo && st.phase == CCD_FLUSH) else $error("irq return wrong");
  a_logic_keeps_carry: assert property (run_exec && ins[15:8] == 8'h0b |=>
    $stable(st.flags.c) && $stable(st.flags.ov) && $stable(st.flags.dc)) else $error("and touched carry");
  a_load_literal: assert property (run_exec && ins[15:8] == 8'h0e && !bus.wr |=>
    st.working_register == $past(ins[7:0]) && $stable(st.flags)) else $error("literal load wrong");
  a_long_write_run: assert property (st.phase == CCD_TABLE && st.tbl_is_wr && ptr_pre[2:0] == NVM_BLOCK_LAST
    |=> nvm_busy [*3] ##1 !nvm_busy && st.phase == CCD_EXEC) else $error("long write not five cycles");
  a_prescale_clear: assert property (bus.wr && bus.addr == RA_TIMER && st.ctrl[CTRL_PSA] |=>
    st.prescale == 3'h0) else $error("prescaler not cleared");
  a_lone_second_nop: assert property (run_exec && ins[15:12] == HI_SECOND && !bus.wr |=>
    st.pc == $past(st.pc) + PC_W'(1) && $stable(st.working_register)) else $error("lone word not nop");
endmodule

// *** design/ccd_pkg.sv ***
// Purpose: shared constants and types for the control, literal and table decoder
// Assumes: word-addressed program memory, 8-bit data path, one 20 MHz clock
// Notes: register offsets index an 8-bit register port
package ccd_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 8;
  // high nibbles of the instruction word
  localparam logic [3:0] HI_LITCTL = 4'h0;
  localparam logic [3:0] HI_RELATIVE = 4'hd;
  localparam logic [3:0] HI_LONG = 4'he;
  localparam logic [3:0] HI_SECOND = 4'hf;
  // second nibble codes inside the 4'he group
  localparam logic [2:0] SUB_CALL = 3'h6;
  localparam logic [3:0] SUB_PTRLOAD = 4'he;
  localparam logic [3:0] SUB_JUMP = 4'hf;
  // literal group codes in bits 11:8
  localparam logic [3:0] LIT_BANK = 4'h1;
  localparam logic [3:0] LIT_SUB = 4'h8;
  localparam logic [3:0] LIT_OR = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'ha;
  localparam logic [3:0] LIT_AND = 4'hb;
  localparam logic [3:0] LIT_RET = 4'hc;
  localparam logic [3:0] LIT_MUL = 4'hd;
  localparam logic [3:0] LIT_LOAD = 4'he;
  localparam logic [3:0] LIT_ADD = 4'hf;
  // control words; the return and table codes leave out their low select bits
  localparam logic [15:0] CW_SLEEP = 16'h0003;
  localparam logic [15:0] CW_WDT = 16'h0004;
  localparam logic [15:0] CW_PUSH = 16'h0005;
  localparam logic [15:0] CW_POP = 16'h0006;
  localparam logic [14:0] CW_INTERRUPT_RETURN_OP = 15'h0008;
  localparam logic [14:0] CW_RETURN = 15'h0009;
  localparam logic [13:0] CW_TABLE_READ_OP = 14'h0002;
  localparam logic [13:0] CW_TABLE_WRITE_OP = 14'h0003;
  // table write: a write to the last byte of a block starts the internal write
  localparam logic [2:0] NVM_BLOCK_LAST = 3'h7;
  localparam int TABLE_WRITE_OP_LONG_CYC = 5;
  localparam int TABLE_WRITE_OP_SHORT_CYC = 2;
  localparam logic [1:0] NVM_WAIT_CNT = 2'(TABLE_WRITE_OP_LONG_CYC - TABLE_WRITE_OP_SHORT_CYC);
  localparam logic [2:0] PRESCALE_MAX = 3'h7;
  // register port offsets
  localparam logic [3:0] RA_WORKING = 4'h0;
  localparam logic [3:0] RA_FLAGS = 4'h1;
  localparam logic [3:0] RA_BANK = 4'h2;
  localparam logic [3:0] RA_CTRL = 4'h3;
  localparam logic [3:0] RA_TIMER = 4'h4;
  localparam logic [3:0] RA_PORT_LATCH = 4'h5;
  localparam logic [3:0] RA_PORT_PINS = 4'h6;
  localparam logic [3:0] RA_PORT_TOGGLE = 4'h7;
  localparam logic [3:0] RA_TABLE_LATCH = 4'h8;
  localparam logic [3:0] RA_PROD_LO = 4'h9;
  localparam logic [3:0] RA_PROD_HI = 4'ha;
  localparam logic [3:0] RA_CORE_STAT = 4'hb;
  // control register fields and reset value
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PSA = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  typedef enum logic [2:0] {
    CCD_EXEC, CCD_FLUSH, CCD_WORD2, CCD_TABLE, CCD_NVM_WAIT, CCD_STANDBY
  } ccd_phase_e;
  typedef struct packed {
    logic c;
    logic dc;
    logic z;
    logic ov;
    logic n;
  } ccd_flags_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccd_bus_s;
endpackage
